// [rtl/rmcp_pkg.sv]
/*
 Package for the modem command and power-override register bank:
 register addresses, reset values, field positions, state codes and carriers.
 Assumes a byte-wide data memory port of the microcontroller on the core clock.
*/
package rmcp_pkg;
  localparam logic [15:0] CMD_A_ADDR = 16'h2200;
  localparam logic [15:0] CMD_B_ADDR = 16'h2201;
  localparam logic [15:0] SPD_ADDR = 16'h2202;
  localparam logic [15:0] SPU_ADDR = 16'h2203;
  localparam logic [15:0] RPD_ADDR = 16'h2204;
  localparam logic [15:0] RPU_ADDR = 16'h2205;

  localparam logic [7:0] CMD_A_RST = 8'hFC;
  localparam logic [7:0] CMD_B_RST = 8'hC7;
  localparam logic [7:0] SPD_RST = 8'hE0;
  localparam logic [7:0] SPU_RST = 8'hFF;
  localparam logic [7:0] RPD_RST = 8'h00;
  localparam logic [7:0] RPU_RST = 8'hFF;

  // Writable bits; reserved bits keep their reset value
  localparam logic [7:0] CMD_A_WMASK = 8'hCF;
  localparam logic [7:0] CMD_B_WMASK = 8'h33;
  localparam logic [7:0] SP_WMASK = 8'h1F;
  localparam logic [7:0] RP_WMASK = 8'hFF;
  // Self-restoring request bits of command A
  localparam logic [7:0] REQ_MASK = 8'hCC;

  localparam int OFF_B = 7;
  localparam int ON_B = 6;
  localparam int ABT_B = 3;
  localparam int SEND_B = 2;
  localparam int TX_PATH_FORCE_ON_B = 1;
  localparam int RX_PATH_FORCE_ON_B = 0;
  localparam int DEC_B = 5;
  localparam int ENC_B = 4;
  localparam int TX_PATH_FORCE_OFF_B = 1;
  localparam int RX_PATH_FORCE_OFF_B = 0;
  localparam int PLLR_B = 4;
  localparam int OBUF_B = 3;
  localparam int OCORE_B = 2;
  localparam int DIV_B = 1;
  localparam int CP_B = 0;
  localparam int LNA_B = 7;

  // Turnaround delay of the transmit and abort sequences, in cycles
  localparam int TURN_DELAY_CYC = 16;

  typedef enum logic [6:0] {
    ST_OFF = 7'h01,
    ST_WAKE = 7'h02,
    ST_RX = 7'h04,
    ST_TURN = 7'h08,
    ST_CCA = 7'h10,
    ST_TX = 7'h20,
    ST_STOP = 7'h40
  } rmcp_state_e;

  typedef struct packed {
    logic modem_rst;
    logic mod_en;
    logic demod_en;
    logic pll_rst;
    logic obuf_pd;
    logic ocore_pd;
    logic div_pd;
    logic cp_pd;
    logic lna_pd;
    logic tx_start;
    logic tx_stop;
    logic tx_done_event;
    logic modem_ready_event;
    logic encrypt_go;
    logic decrypt_go;
  } rmcp_pwr_s;

  typedef struct packed {
    rmcp_state_e st;
    logic [15:0] cnt;
    logic [7:0] ca;
    logic [7:0] cb;
    logic [7:0] spd;
    logic [7:0] spu;
    logic [7:0] rpd;
    logic [7:0] rpu;
    logic [7:0] rdata;
    rmcp_pwr_s o;
  } rmcp_regs_s;
endpackage

// [rtl/rmcp_regs.sv]
/*
 Modem command and power-override register bank with the modem sequencer.
 Assumes the data memory port, CCA and transmit status all run on clk_i.
*/
// Summary of operation
// RL1 - Writing 0 to modem off request resets modem, powers RF down, bit returns 1.
// RL2 - Writing 0 to modem on request starts modem; bit returns 1 once on.
// RL3 - Writing 0 to abort during transmission stops it; receive-ready after delay.
// RL4 - Writing 0 to send request reaches transmit-ready after delay; sends on idle.
// RL5 - Busy channel holds off a requested transmission until the channel is idle.
// RL6 - Send bit returns 1 at finish; only a successful finish raises done event.
// RL7 - Modulator forced on, forced off, or automatic while sending.
// RL8 - Demodulator forced on, forced off, or automatic.
// RL9 - Software should leave both transmit path force bits at 0.
// RL10 - Decrypt start drives the MAC; hardware never clears it.
// RL11 - Encrypt start drives the MAC; hardware never clears it.
// RL12 - PLL reset: both 1 automatic, clear-only forces reset, else released.
// RL13 - Oscillator buffer: both 1 automatic, up-only forces down, else up.
// RL14 - Oscillator core: both 1 automatic, up-only forces down, else up.
// RL15 - Divider: both 1 automatic, up-only forces down, else up.
// RL16 - Charge pump: both 1 automatic, up-only forces down, else up.
// RL17 - Receive LNA: both 1 automatic, up-only forces down, else up.
// RL18 - Modem ready event pulses once RF is stable after an on request.
// RL19 - All registers sit in the microcontroller data memory space.
// RL20 - Writing 1 to a self-restoring request bit does nothing.
`timescale 1ns/1ps
module rmcp_regs #(
  parameter int TURN_CYC = rmcp_pkg::TURN_DELAY_CYC
) (
  input wire logic clk_i, // Core clock
  input wire logic reset_i, // Async reset, high
  input wire logic [15:0] addr_i, // Data memory address
  input wire logic wr_en_i, // Write strobe
  input wire logic rd_en_i, // Read strobe
  input wire logic [7:0] wdata_i, // Write data
  output logic [7:0] rdata_o, // Read data, next cycle
  input wire logic rf_stable_i, // RF settled after wake
  input wire logic cca_idle_i, // Channel idle
  input wire logic tx_done_i, // Packet sent
  input wire logic tx_fail_i, // Packet ended abnormally
  output rmcp_pkg::rmcp_state_e state_o, // Sequencer state
  output rmcp_pkg::rmcp_pwr_s pwr_o // Power and event outputs
);
  import rmcp_pkg::*;

  rmcp_regs_s q;
  rmcp_regs_s next_q;
  logic wr_a;
  logic off_w;
  logic tx_busy;

  // Mapped as plain data memory bytes
  assign wr_a = wr_en_i && (addr_i == CMD_A_ADDR); // [RL19]
  assign off_w = wr_a && !wdata_i[OFF_B];
  assign tx_busy = (q.st == ST_TURN) || (q.st == ST_CCA) || (q.st == ST_TX);

  // Override pair: both set hands over to the sequencer
  function automatic logic pair_act(input logic d, input logic u, input logic auto_v);
    pair_act = (d && u) ? auto_v : (u && !d);
  endfunction

  function automatic logic force_en(input logic on, input logic off, input logic auto_v);
    force_en = on ? 1'b1 : (off ? 1'b0 : auto_v);
  endfunction

  always_comb begin
    logic a_rx;
    logic a_tx;
    logic a_off;
    a_rx = 1'b0;
    a_tx = 1'b0;
    a_off = 1'b0;
    next_q = q;
    next_q.o.tx_start = 1'b0;
    next_q.o.tx_stop = 1'b0;
    next_q.o.tx_done_event = 1'b0;
    next_q.o.modem_ready_event = 1'b0;
    if (wr_a) begin
      // Request bits only accept a 0; a written 1 leaves them alone
      next_q.ca = (q.ca & ~CMD_A_WMASK) | (wdata_i & CMD_A_WMASK & ~REQ_MASK)
        | (q.ca & wdata_i & REQ_MASK); // [RL20]
    end
    if (wr_en_i && addr_i == CMD_B_ADDR) begin
      next_q.cb = (q.cb & ~CMD_B_WMASK) | (wdata_i & CMD_B_WMASK);
    end
    if (wr_en_i && addr_i == SPD_ADDR) begin
      next_q.spd = (q.spd & ~SP_WMASK) | (wdata_i & SP_WMASK);
    end
    if (wr_en_i && addr_i == SPU_ADDR) begin
      next_q.spu = (q.spu & ~SP_WMASK) | (wdata_i & SP_WMASK);
    end
    if (wr_en_i && addr_i == RPD_ADDR) begin
      next_q.rpd = (q.rpd & ~RP_WMASK) | (wdata_i & RP_WMASK);
    end
    if (wr_en_i && addr_i == RPU_ADDR) begin
      next_q.rpu = (q.rpu & ~RP_WMASK) | (wdata_i & RP_WMASK);
    end

    case (q.st)
      ST_OFF: begin
        if (!next_q.ca[ON_B]) begin
          next_q.st = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (rf_stable_i) begin
          next_q.st = ST_RX;
          next_q.ca[ON_B] = 1'b1; // [RL2]
          next_q.o.modem_ready_event = 1'b1; // [RL18]
        end
      end
      ST_RX: begin
        next_q.ca[ON_B] = 1'b1;
        if (!next_q.ca[SEND_B]) begin
          next_q.st = ST_TURN;
          next_q.cnt = 16'(TURN_CYC - 1); // [RL4]
        end
      end
      ST_TURN: begin
        next_q.ca[ON_B] = 1'b1;
        next_q.cnt = q.cnt - 16'h0001;
        if (q.cnt == 16'h0000) begin
          next_q.st = ST_CCA;
        end
      end
      ST_CCA: begin
        next_q.ca[ON_B] = 1'b1;
        // Busy channel defers the start indefinitely
        if (cca_idle_i) begin
          next_q.st = ST_TX; // [RL4] [RL5]
          next_q.o.tx_start = 1'b1;
        end
      end
      ST_TX: begin
        next_q.ca[ON_B] = 1'b1;
        if (tx_done_i) begin
          next_q.st = ST_RX;
          next_q.ca[SEND_B] = 1'b1; // [RL6]
          next_q.o.tx_done_event = 1'b1;
        end else if (tx_fail_i) begin
          next_q.st = ST_RX;
          next_q.ca[SEND_B] = 1'b1; // [RL6]
        end
      end
      ST_STOP: begin
        next_q.ca[ON_B] = 1'b1;
        next_q.cnt = q.cnt - 16'h0001;
        if (q.cnt == 16'h0000) begin
          next_q.st = ST_RX;
          next_q.ca[ABT_B] = 1'b1; // [RL3]
        end
      end
      default: begin
        next_q.st = ST_OFF;
      end
    endcase

    if (!next_q.ca[ABT_B] && q.st != ST_STOP) begin
      if (tx_busy) begin
        // Abort wins over a finish in the same cycle
        next_q.st = ST_STOP; // [RL3]
        next_q.cnt = 16'(TURN_CYC - 1);
        next_q.ca[SEND_B] = 1'b1;
        next_q.o.tx_start = 1'b0;
        next_q.o.tx_done_event = 1'b0;
        next_q.o.tx_stop = 1'b1;
      end else begin
        next_q.ca[ABT_B] = 1'b1;
      end
    end

    if (off_w) begin
      // Off beats every other request written alongside it
      next_q.st = ST_OFF; // [RL1]
      next_q.ca = next_q.ca | REQ_MASK;
      next_q.o.tx_start = 1'b0;
      next_q.o.tx_stop = 1'b0;
      next_q.o.tx_done_event = 1'b0;
      next_q.o.modem_ready_event = 1'b0;
    end

    a_off = (next_q.st == ST_OFF);
    a_tx = (next_q.st == ST_TURN) || (next_q.st == ST_CCA) || (next_q.st == ST_TX);
    a_rx = (next_q.st == ST_RX) || (next_q.st == ST_CCA) || (next_q.st == ST_STOP);
    next_q.o.modem_rst = a_off; // [RL1]
    next_q.o.mod_en = force_en(next_q.ca[TX_PATH_FORCE_ON_B], next_q.cb[TX_PATH_FORCE_OFF_B], a_tx); // [RL7]
    next_q.o.demod_en = force_en(next_q.ca[RX_PATH_FORCE_ON_B], next_q.cb[RX_PATH_FORCE_OFF_B], a_rx); // [RL8]
    next_q.o.pll_rst = pair_act(next_q.spd[PLLR_B], next_q.spu[PLLR_B], a_off); // [RL12]
    next_q.o.obuf_pd = pair_act(next_q.spd[OBUF_B], next_q.spu[OBUF_B], a_off); // [RL13]
    next_q.o.ocore_pd = pair_act(next_q.spd[OCORE_B], next_q.spu[OCORE_B], a_off); // [RL14]
    next_q.o.div_pd = pair_act(next_q.spd[DIV_B], next_q.spu[DIV_B], a_off); // [RL15]
    next_q.o.cp_pd = pair_act(next_q.spd[CP_B], next_q.spu[CP_B], a_off); // [RL16]
    next_q.o.lna_pd = pair_act(next_q.rpd[LNA_B], next_q.rpu[LNA_B], !a_rx); // [RL17]
    next_q.o.encrypt_go = next_q.cb[ENC_B]; // [RL11]
    next_q.o.decrypt_go = next_q.cb[DEC_B]; // [RL10]

    if (rd_en_i) begin
      case (addr_i)
        CMD_A_ADDR: next_q.rdata = q.ca;
        CMD_B_ADDR: next_q.rdata = q.cb;
        SPD_ADDR: next_q.rdata = q.spd;
        SPU_ADDR: next_q.rdata = q.spu;
        RPD_ADDR: next_q.rdata = q.rpd;
        RPU_ADDR: next_q.rdata = q.rpu;
        default: next_q.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      q.st <= ST_OFF;
      q.cnt <= 16'h0000;
      q.ca <= CMD_A_RST;
      q.cb <= CMD_B_RST;
      q.spd <= SPD_RST;
      q.spu <= SPU_RST;
      q.rpd <= RPD_RST;
      q.rpu <= RPU_RST;
      q.rdata <= 8'h00;
      // Same decode as the reset field values, so nothing glitches at release
      q.o <= '{modem_rst: 1'b1, pll_rst: 1'b1, obuf_pd: 1'b1, ocore_pd: 1'b1, div_pd: 1'b1,
        cp_pd: 1'b1, lna_pd: 1'b1, default: 1'b0};
    end else begin
      q <= next_q;
    end
  end

  assign rdata_o = q.rdata;
  assign state_o = q.st;
  assign pwr_o = q.o;

  default clocking cb_main @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  chk_off_request: assert property (off_w |=> pwr_o.modem_rst && q.ca[OFF_B] && q.st == ST_OFF)
    else $error("modem off request not honoured"); // [RL1]
  chk_ready_event: assert property (q.st == ST_WAKE && rf_stable_i && !off_w
    |=> pwr_o.modem_ready_event && q.ca[ON_B] && q.st == ST_RX)
    else $error("modem ready not signalled"); // [RL2]
  chk_abort_return: assert property (q.st == ST_STOP && q.cnt == 16'h0000 && !off_w
    |=> q.st == ST_RX && q.ca[ABT_B])
    else $error("abort did not return to receive"); // [RL3]
  chk_turn_delay: assert property (q.st == ST_RX && !next_q.ca[SEND_B] && !off_w
    && next_q.ca[ABT_B] |=> q.st == ST_TURN && q.cnt == 16'(TURN_CYC - 1))
    else $error("transmit turnaround not started"); // [RL4]
  chk_cca_hold: assert property (q.st == ST_TX && $past(q.st) != ST_TX
    |-> $past(cca_idle_i) && pwr_o.tx_start)
    else $error("transmission began on busy channel"); // [RL5]
  chk_tx_done: assert property (q.st == ST_TX && tx_done_i && !off_w && next_q.ca[ABT_B]
    |=> pwr_o.tx_done_event && q.ca[SEND_B] && q.st == ST_RX)
    else $error("successful finish not reported"); // [RL6]
  chk_tx_fail: assert property (q.st == ST_TX && !tx_done_i && tx_fail_i && !off_w
    |=> !pwr_o.tx_done_event && q.ca[SEND_B])
    else $error("abnormal finish mishandled"); // [RL6]
  chk_mod_force: assert property (q.ca[TX_PATH_FORCE_ON_B] && !wr_en_i |=> pwr_o.mod_en)
    else $error("modulator force on ignored"); // [RL7]
  chk_demod_force: assert property (!q.ca[RX_PATH_FORCE_ON_B] && q.cb[RX_PATH_FORCE_OFF_B] && !wr_en_i
    |=> !pwr_o.demod_en)
    else $error("demodulator force off ignored"); // [RL8]
  chk_decrypt_hold: assert property (q.cb[DEC_B] && !wr_en_i |=> pwr_o.decrypt_go)
    else $error("decrypt start cleared by hardware"); // [RL10]
  chk_encrypt_hold: assert property (q.cb[ENC_B] && !wr_en_i |=> pwr_o.encrypt_go)
    else $error("encrypt start cleared by hardware"); // [RL11]
  chk_pll_reset: assert property (!q.spd[PLLR_B] && q.spu[PLLR_B] && !wr_en_i
    |=> pwr_o.pll_rst)
    else $error("forced synthesizer reset missing"); // [RL12]
  chk_cp_forced: assert property (!q.spu[CP_B] && !wr_en_i |=> !pwr_o.cp_pd)
    else $error("charge pump not forced up"); // [RL16]
  chk_lna_down: assert property (!q.rpd[LNA_B] && q.rpu[LNA_B] && !wr_en_i
    |=> pwr_o.lna_pd)
    else $error("receive amplifier not forced down"); // [RL17]
  chk_write_one: assert property (wr_a && (wdata_i & REQ_MASK) == REQ_MASK && q.st == ST_RX
    && q.ca[SEND_B] |=> q.st == ST_RX)
    else $error("written one started a request"); // [RL20]

  cov_wake: cover property (q.st == ST_WAKE ##1 q.st == ST_RX);
  cov_send: cover property (q.st == ST_CCA && !cca_idle_i ##1 q.st == ST_CCA ##1 q.st == ST_TX);
  cov_abort: cover property (q.st == ST_TX ##1 q.st == ST_STOP);
  cov_done: cover property (pwr_o.tx_done_event);
endmodule // rmcp_regs

// [tb/rmcp_rf_model.sv]
/*
 RF side model: settles some cycles after wake, reports the channel busy
 for a set span, then ends a packet well, badly or never.
 Assumes the sequencer state of the register bank is visible to it.
*/
`timescale 1ns/1ps
module rmcp_rf_model (
  input wire logic clk_i, // Core clock
  input wire logic reset_i, // Async reset, high
  input rmcp_pkg::rmcp_state_e state_i, // Sequencer state
  input wire logic [7:0] busy_i, // Busy cycles in CCA
  input wire logic [1:0] mode_i, // 0 ok, 1 fail, 2 endless
  output logic rf_stable_o, // RF settled
  output logic cca_idle_o, // Channel idle
  output logic tx_done_o, // Packet sent
  output logic tx_fail_o // Packet broken
);
  import rmcp_pkg::*;
  rmcp_state_e last;
  logic [7:0] cnt;
  logic [7:0] cnt_now;
  // Cycles spent in the present state, zero in its first cycle
  assign cnt_now = (state_i != last) ? 8'h00 : cnt;
  // Busy for exactly busy_i cycles of an assessment, never a stale idle
  assign cca_idle_o = (state_i == ST_CCA) && (cnt_now >= busy_i);
  assign rf_stable_o = (state_i == ST_WAKE) && (cnt_now >= 8'h05);
  assign tx_done_o = (state_i == ST_TX) && (cnt_now == 8'h06) && (mode_i == 2'b00);
  assign tx_fail_o = (state_i == ST_TX) && (cnt_now == 8'h06) && (mode_i == 2'b01);
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      last <= ST_OFF;
      cnt <= 8'h00;
    end else begin
      last <= state_i;
      cnt <= (cnt_now == 8'hFF) ? cnt_now : cnt_now + 8'h01;
    end
  end
endmodule // rmcp_rf_model

// [tb/testbench.sv]
/*
 Self-checking bench for the command and power register bank.
 Assumes rmcp_pkg, the register bank and the RF side model compiled first.
*/
`timescale 1ns/1ps
module testbench;
  import rmcp_pkg::*;
  localparam int TC = 4;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [15:0] addr_i = 16'h0000;
  logic wr_en_i = 1'b0;
  logic rd_en_i = 1'b0;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] rdata_o;
  logic rf_stable_i, cca_idle_i, tx_done_i, tx_fail_i;
  rmcp_state_e state_o;
  rmcp_state_e st = ST_OFF;
  rmcp_pwr_s pwr_o;
  logic [7:0] busy = 8'h03;
  logic [1:0] mode = 2'b00;
  int n_errors = 0;
  int n_tests = 0;
  int ca = 8'hFC, cb = 8'hC7, spd = 8'hE0, spu = 8'hFF, rpd = 8'h00, rpu = 8'hFF;
  int n;
  bit [31:0] seed = 39408;
  logic [15:0] a16;
  logic [7:0] d8;
  always #2 clk_i = ~clk_i;
  rmcp_regs #(.TURN_CYC(TC)) rmcp_regs_inst (.clk_i(clk_i), .reset_i(reset_i),
    .addr_i(addr_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .wdata_i(wdata_i),
    .rdata_o(rdata_o), .rf_stable_i(rf_stable_i), .cca_idle_i(cca_idle_i),
    .tx_done_i(tx_done_i), .tx_fail_i(tx_fail_i), .state_o(state_o), .pwr_o(pwr_o));
  rmcp_rf_model rmcp_rf_model_inst (.clk_i(clk_i), .reset_i(reset_i), .state_i(state_o),
    .busy_i(busy), .mode_i(mode), .rf_stable_o(rf_stable_i), .cca_idle_o(cca_idle_i),
    .tx_done_o(tx_done_i), .tx_fail_o(tx_fail_i));
  function automatic bit [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic bit pd(bit d, bit u, bit a);
    return (d && u) ? a : (!d && u);
  endfunction
  function automatic bit fen(bit on, bit off, bit a);
    return on ? 1'b1 : (off ? 1'b0 : a);
  endfunction
  function automatic logic [7:0] regv(logic [15:0] a);
    case (a)
      CMD_A_ADDR: return ca[7:0];
      CMD_B_ADDR: return cb[7:0];
      SPD_ADDR: return spd[7:0];
      SPU_ADDR: return spu[7:0];
      RPD_ADDR: return rpd[7:0];
      RPU_ADDR: return rpu[7:0];
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic ev(int k);
    case (k)
      0: return pwr_o.modem_ready_event;
      1: return pwr_o.tx_start;
      2: return pwr_o.tx_done_event;
      3: return state_o == ST_RX;
      default: return pwr_o.tx_stop;
    endcase
  endfunction
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(logic [15:0] a, logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_en_i <= 1'b1;
    @(posedge clk_i);
    wr_en_i <= 1'b0;
    #1;
    // Request bits of command A always settle back to 1, only its force bits are kept
    case (a)
      CMD_A_ADDR: ca = 8'hFC | d[1:0];
      CMD_B_ADDR: cb = 8'hC4 | (d & 8'h33);
      SPD_ADDR: spd = 8'hE0 | d[4:0];
      SPU_ADDR: spu = 8'hE0 | d[4:0];
      RPD_ADDR: rpd = d;
      RPU_ADDR: rpu = d;
      default: ;
    endcase
  endtask
  task automatic rd(logic [15:0] a, logic [7:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_en_i <= 1'b1;
    @(posedge clk_i);
    rd_en_i <= 1'b0;
    #1;
    chk("rdata", rdata_o, exp);
  endtask
  task automatic wait_ev(int k, int lim);
    for (n = 0; n < lim; n++) begin
      if (ev(k) === 1'b1) break;
      @(posedge clk_i);
      #1;
    end
  endtask
  task automatic cpwr();
    bit off;
    off = (st == ST_OFF);
    chk("state", state_o, st);
    chk("modem_rst", pwr_o.modem_rst, off);
    chk("pll_rst", pwr_o.pll_rst, pd(spd[4], spu[4], off));
    chk("obuf_pd", pwr_o.obuf_pd, pd(spd[3], spu[3], off));
    chk("ocore_pd", pwr_o.ocore_pd, pd(spd[2], spu[2], off));
    chk("div_pd", pwr_o.div_pd, pd(spd[1], spu[1], off));
    chk("cp_pd", pwr_o.cp_pd, pd(spd[0], spu[0], off));
    chk("lna_pd", pwr_o.lna_pd, pd(rpd[7], rpu[7], off));
    chk("mod_en", pwr_o.mod_en, fen(ca[1], cb[1], 1'b0));
    chk("demod_en", pwr_o.demod_en, fen(ca[0], cb[0], !off));
    chk("crypt", {pwr_o.encrypt_go, pwr_o.decrypt_go}, {cb[4], cb[5]});
  endtask
  task automatic pwr_table();
    bit [1:0] k;
    for (int i = 0; i < 4; i++) begin
      k = 2'(i);
      wr(SPD_ADDR, {3'b111, {5{k[1]}}});
      wr(SPU_ADDR, {3'b111, {5{k[0]}}});
      wr(RPD_ADDR, {k[1], 7'h00});
      wr(RPU_ADDR, {k[0], 7'h7F});
      wr(CMD_A_ADDR, 8'hFC | {k[0], k[1]});
      wr(CMD_B_ADDR, 8'hC4 | (8'h11 * k));
      cpwr();
    end
  endtask
  task automatic send(logic [1:0] m, logic [7:0] b);
    @(posedge clk_i);
    mode <= m;
    busy <= b;
    wr(CMD_A_ADDR, 8'hF8);
    wait_ev(1, 100);
    chk("hold", 16'(n), 16'(TC + 1 + b));
    chk("mod_tx", pwr_o.mod_en, 1'b1);
    if (m == 2'b10) return;
    wait_ev(2, 30);
    chk("done", n < 30, m == 2'b00);
    wait_ev(3, 30);
    chk("back_rx", n < 30, 1'b1);
    rd(CMD_A_ADDR, regv(CMD_A_ADDR));
  endtask
  initial begin
    #100000;
    n_errors++;
    summarize();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    #1;
    cpwr();
    for (int a = 0; a < 7; a++) rd(CMD_A_ADDR + 16'(a), regv(CMD_A_ADDR + 16'(a)));
    pwr_table();
    wr(CMD_A_ADDR, 8'hBC);
    wait_ev(0, 50);
    chk("ready", n < 50, 1'b1);
    st = ST_RX;
    @(posedge clk_i);
    #1;
    rd(CMD_A_ADDR, regv(CMD_A_ADDR));
    pwr_table();
    for (int i = 0; i < 30; i++) begin
      a16 = CMD_A_ADDR + 16'(xs() % 6);
      d8 = 8'(xs());
      if (a16 == CMD_A_ADDR) d8 |= 8'hCC;
      wr(a16, d8);
      cpwr();
      rd(a16, regv(a16));
    end
    wr(CMD_A_ADDR, 8'hFC);
    wr(CMD_B_ADDR, 8'hC4);
    send(2'b00, 8'h00);
    send(2'b00, 8'(xs() % 20));
    send(2'b01, 8'h02);
    send(2'b10, 8'h01);
    wr(CMD_A_ADDR, 8'hF4);
    wait_ev(4, 1);
    chk("stop", n, 16'h0000);
    wait_ev(3, TC + 3);
    chk("turn", (n >= TC - 1) && (n <= TC + 1), 1'b1);
    chk("no_done", pwr_o.tx_done_event, 1'b0);
    wr(CMD_A_ADDR, 8'hF4);
    wr(CMD_A_ADDR, 8'hFC);
    chk("idle", state_o, ST_RX);
    rd(CMD_A_ADDR, 8'hFC);
    wr(CMD_A_ADDR, 8'h7C);
    st = ST_OFF;
    @(posedge clk_i);
    #1;
    cpwr();
    rd(CMD_A_ADDR, 8'hFC);
    summarize();
  end
endmodule // testbench
